// [bench/cbbs_mem_model.sv]
// Memory side model: each mapped byte reads back a mix of its address.
// Assumes the sequencer samples read data in the byte's last cycle.
`timescale 1ns/100ps
`default_nettype none
module cbbs_mem_model
  import cbbs_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       strobe_in,
  input  wire cbbs_mem_t  mem_in,
  output logic [7:0]      rdata_out
);
  logic [7:0] last_r = 8'h00;
  always @(posedge clock_in) if (strobe_in) last_r <= rdata_out;
  // Off the bus the lines flip, so a stale sample is never a match by luck.
  assign rdata_out = strobe_in ? mem_in.addr[7:0] ^ mem_in.addr[15:8] ^ 8'h3C : ~last_r;
endmodule
`default_nettype wire

// [bench/cbbs_seq_asserts.sv]
// Port checker of the CPU byte bus sequencer.
// Assumes it is bound to every cbbs_seq instance.
`timescale 1ns/100ps
`default_nettype none
module cbbs_seq_asserts
  import cbbs_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire cbbs_req_t req_in,
  input wire logic req_ready_out,
  input wire logic done_out,
  input wire logic [15:0] rdata_out,
  input wire logic mem_strobe_out,
  input wire cbbs_mem_t mem_out
);
  wire logic [15:0] a = req_in.addr;
  wire logic acc = req_valid_in && req_ready_out;
  wire logic slow = a <= 16'h02FF || (a >= 16'h2400 && a <= 16'h2BFF);
  wire logic fast = (a >= 16'h0400 && a <= 16'h0FFF) || a >= 16'h4000;
  // Both bytes of a fast word stay fast unless the low 12 bits are all ones.
  wire logic wf = acc && req_in.word && fast && a[11:0] != 12'hFFF;
  cbbs_req_t req_r;
  always_ff @(posedge clock_in) if (acc) req_r <= req_in;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  slow_byte_a: assert property (acc && !req_in.word && slow |=> !done_out[*2] ##1 done_out)
    else $error("slow byte latency");
  fast_byte_a: assert property (acc && !req_in.word && fast |=> !done_out ##1 done_out)
    else $error("fast byte latency");
  byte_width_a: assert property (done_out && !req_r.word && !req_r.write |-> rdata_out[15:8] == 8'h00)
    else $error("byte read upper half");
  word_split_a: assert property (acc && req_in.word && slow && a[7:0] != 8'hFF
    |=> mem_strobe_out[*4] ##1 done_out) else $error("slow word split");
  chip_only_a: assert property (acc && !req_in.word && !slow && !fast |=> !mem_strobe_out)
    else $error("strobe on unmapped byte");
  word_order_a: assert property (wf |=> mem_out.addr == req_r.addr
    ##1 mem_out.addr == req_r.addr + 16'h1) else $error("word byte order");
  word_bytes_a: assert property (wf && req_in.write |=> mem_out.wdata == req_r.wdata[7:0]
    ##1 mem_out.wdata == req_r.wdata[15:8]) else $error("word byte lanes");
endmodule
bind cbbs_seq cbbs_seq_asserts u_chk (.*);
`default_nettype wire

// [bench/test_cpu_byte_bus_sequencer.sv]
// Self-checking bench of the CPU byte bus sequencer.
// Assumes cbbs_pkg and the memory model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_cpu_byte_bus_sequencer;
  import cbbs_pkg::*;
  logic clock_in = 1'b0, rst_n_in = 1'b0, req_valid_in = 1'b0;
  cbbs_req_t req_in = '0;
  logic req_ready_out, done_out, unmapped_out, mem_strobe_out;
  logic [15:0] rdata_out;
  logic [7:0] mem_rdata_in;
  cbbs_mem_t mem_out;
  cbbs_space_t mem_space_out;
  logic [31:0] r;
  logic [15:0] dir [8] = '{16'h0400, 16'h4001, 16'h2401, 16'h02FE,
                           16'h1000, 16'h0401, 16'h0010, 16'hFFFF};
  int n_fail = 0, total_checks = 0, seed = 4444, n;
  always #5 clock_in = ~clock_in;
  cbbs_seq DUT (.*);
  cbbs_mem_model mem (.clock_in(clock_in), .strobe_in(mem_strobe_out), .mem_in(mem_out),
                      .rdata_out(mem_rdata_in));
  function int cyc(int a);
    if (a <= 16'h02FF || (a >= 16'h2400 && a <= 16'h2BFF)) return 2;
    if ((a >= 16'h0400 && a <= 16'h0FFF) || a >= 16'h4000) return 1;
    return 0;
  endfunction
  function cbbs_space_t spc(int a);
    if (a <= 16'h02FF) return CBBS_SP_SFR;
    if (a >= 16'h0400 && a <= 16'h0FFF) return CBBS_SP_RAM;
    if (a >= 16'h2400 && a <= 16'h2BFF) return CBBS_SP_DFL;
    if (a >= 16'h4000) return CBBS_SP_ROM;
    return CBBS_SP_NONE;
  endfunction
  function int byt(int a);
    return cyc(a) > 0 ? ((a & 255) ^ (a >> 8) ^ 8'h3C) : 255;
  endfunction
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic op(logic w, logic wd, logic [15:0] a, logic [15:0] d);
    logic [15:0] a1;
    int c0, c1;
    a1 = a + 16'h1;
    c0 = cyc(a);
    c1 = wd ? cyc(a1) : 1;
    @(posedge clock_in);
    req_valid_in <= 1'b1;
    req_in <= '{w, wd, a, d};
    @(posedge clock_in);
    req_valid_in <= 1'b0;
    #1;
    chk("space", 16'(spc(a)), 16'(mem_space_out));
    chk("ready busy", 16'h0000, 16'(req_ready_out));
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
      #1;
    end while (done_out !== 1'b1 && n < 20);
    chk("unmapped", 16'(c0 == 0 || c1 == 0), 16'(unmapped_out));
    if (c0 > 0 && c1 > 0) chk("cycles", 16'(c0 + (wd ? c1 : 0)), 16'(n));
    chk("ready idle", 16'h0001, 16'(req_ready_out));
    if (!w) chk("rdata", wd ? 16'((byt(a1) << 8) | byt(a)) : 16'(byt(a)), rdata_out);
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    results;
  end
  initial begin
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 8; i++) op(1'(i / 4), 1'(i % 2), dir[i], 16'hA55A);
    $display("Directed accesses done");
    repeat (60) begin
      r = $random(seed);
      op(r[0], r[1], r[31:16], {r[15:2], 2'h3});
    end
    $display("Random accesses done");
    results;
  end
endmodule
`default_nettype wire

// [verilog/cbbs_decode.sv]
// Address decoder of the CPU byte bus sequencer.
// Assumes a purely combinational use inside the sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "cbbs_defs.svh"
module cbbs_decode (
  // Address in
  input  wire logic [15:0]         addr_in,
  // Decoded space and byte cycle count
  output cbbs_pkg::cbbs_space_t    space_out,
  output logic [1:0]               cycles_out
);
  import cbbs_pkg::*;

  wire in_sfr = (addr_in >= `CBBS_SFR_LO) && (addr_in <= `CBBS_SFR_HI);
  wire in_ram = (addr_in >= `CBBS_RAM_LO) && (addr_in <= `CBBS_RAM_HI);
  wire in_dfl = (addr_in >= `CBBS_DFL_LO) && (addr_in <= `CBBS_DFL_HI);
  wire in_rom = (addr_in >= `CBBS_ROM_LO) && (addr_in <= `CBBS_ROM_HI);

  // Only internal areas exist; anything else is unmapped.
  assign space_out = in_sfr ? CBBS_SP_SFR :
                     in_ram ? CBBS_SP_RAM :
                     in_dfl ? CBBS_SP_DFL :
                     in_rom ? CBBS_SP_ROM : CBBS_SP_NONE;
  assign cycles_out = (in_sfr || in_dfl) ? `CBBS_SLOW_CYC : `CBBS_FAST_CYC;
endmodule
`default_nettype wire

// [verilog/cbbs_defs.svh]
// Constants of the CPU byte bus sequencer: address map and cycle counts.
// Assumes a 16-bit CPU address space holding only on-chip areas.
`ifndef CBBS_DEFS_SVH
`define CBBS_DEFS_SVH
// Address map, inclusive bounds.
`define CBBS_SFR_LO    16'h0000
`define CBBS_SFR_HI    16'h02FF
`define CBBS_RAM_LO    16'h0400
`define CBBS_RAM_HI    16'h0FFF
`define CBBS_DFL_LO    16'h2400
`define CBBS_DFL_HI    16'h2BFF
`define CBBS_ROM_LO    16'h4000
`define CBBS_ROM_HI    16'hFFFF
// Cycles per byte transfer.
`define CBBS_SLOW_CYC  2'h2
`define CBBS_FAST_CYC  2'h1
`endif

// [verilog/cbbs_pkg.sv]
// Types shared by the CPU byte bus sequencer files.
// Assumes cbbs_defs.svh supplies the numeric constants.
package cbbs_pkg;
  typedef enum logic [2:0] {
    CBBS_SP_NONE,
    CBBS_SP_SFR,
    CBBS_SP_RAM,
    CBBS_SP_DFL,
    CBBS_SP_ROM
  } cbbs_space_t;

  typedef struct packed {
    logic        write;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cbbs_req_t;

  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cbbs_mem_t;
endpackage

// [verilog/cbbs_seq.sv]
// CPU byte bus sequencer: turns CPU byte and word requests into byte
// cycles on the one-byte internal memory bus.
// Assumes the memories answer read data combinationally within the cycle
// in which the sequencer presents the address, and reset aborts all work.
`timescale 1ns/100ps
`default_nettype none
`include "cbbs_defs.svh"
module cbbs_seq (
  // Clock and reset
  input  wire logic                clock_in,
  input  wire logic                rst_n_in,
  // CPU request side
  input  wire logic                req_valid_in,
  input  wire cbbs_pkg::cbbs_req_t req_in,
  output logic                     req_ready_out,
  output logic                     done_out,
  output logic                     unmapped_out,
  output logic [15:0]              rdata_out,
  // Memory byte bus
  output logic                     mem_strobe_out,
  output cbbs_pkg::cbbs_mem_t      mem_out,
  output cbbs_pkg::cbbs_space_t    mem_space_out,
  input  wire logic [7:0]          mem_rdata_in
);
  import cbbs_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CBBS_IDLE,
    CBBS_LOW,
    CBBS_HIGH
  } cbbs_state_t;

  cbbs_state_t state_r;
  cbbs_state_t state_nxt;
  cbbs_req_t   req_r;
  logic [1:0]  cnt_r;
  logic [7:0]  low_r;
  logic [15:0] rdata_r;
  logic        done_r;
  logic        unmapped_r;

  // ---------------------------------------------------------------
  // Byte address and decode
  // ---------------------------------------------------------------
  wire         busy      = (state_r != CBBS_IDLE);
  wire         second    = (state_r == CBBS_HIGH);
  wire  [15:0] byte_addr = second ? 16'(req_r.addr + 16'h0001) : req_r.addr;
  cbbs_space_t space;
  wire  [1:0]  cycles;

  cbbs_decode u_decode (
    .addr_in    (byte_addr),
    .space_out  (space),
    .cycles_out (cycles)
  );

  // The byte ends when its count runs out; the slow spaces hold one wait.
  wire byte_end  = busy && (cnt_r == (cycles - 2'h1));
  wire last_byte = second || !req_r.word;
  wire accept    = req_valid_in && !busy;

  assign req_ready_out  = !busy;
  assign mem_strobe_out = busy && (space != CBBS_SP_NONE);
  assign mem_space_out  = space;
  assign mem_out.write  = req_r.write;
  assign mem_out.addr   = byte_addr;
  // Only one byte lane reaches the memories.
  assign mem_out.wdata  = second ? req_r.wdata[15:8] : req_r.wdata[7:0];
  assign done_out       = done_r;
  assign unmapped_out   = unmapped_r;
  assign rdata_out      = rdata_r;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CBBS_IDLE: begin
        if (accept) begin
          state_nxt = CBBS_LOW;
        end
      end
      CBBS_LOW: begin
        if (byte_end) begin
          state_nxt = req_r.word ? CBBS_HIGH : CBBS_IDLE;
        end
      end
      CBBS_HIGH: begin
        if (byte_end) begin
          state_nxt = CBBS_IDLE;
        end
      end
      default: begin
        state_nxt = CBBS_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_r <= CBBS_IDLE;
      cnt_r   <= 2'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= (accept || byte_end) ? 2'h0 : 2'(cnt_r + 2'h1);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      req_r <= '0;
    end else if (accept) begin
      req_r <= req_in;
    end
  end

  // Low byte is held so the word reads back whole, low address in bits 7:0.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      low_r <= 8'h00;
    end else if (byte_end && !second) begin
      low_r <= mem_strobe_out ? mem_rdata_in : 8'hFF;
    end
  end

  wire [7:0]  cur_byte = mem_strobe_out ? mem_rdata_in : 8'hFF;
  wire [15:0] word_rd  = {cur_byte, low_r};
  wire [15:0] byte_rd  = {8'h00, cur_byte};

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rdata_r    <= 16'h0000;
      done_r     <= 1'b0;
      unmapped_r <= 1'b0;
    end else begin
      done_r <= byte_end && last_byte;
      if (accept) begin
        unmapped_r <= 1'b0;
      end else if (byte_end && (space == CBBS_SP_NONE)) begin
        unmapped_r <= 1'b1;
      end
      if (byte_end && last_byte && !req_r.write) begin
        rdata_r <= req_r.word ? word_rd : byte_rd;
      end
    end
  end
endmodule
`default_nettype wire
